//--- verilog/tesc_top.sv
// Decided for this implementation: the Avalon-MM slave port and the register offsets.
`timescale 1ns/1ps
module tesc_top #(
	parameter int POS_WIDTH = 32,
	parameter longint FACTORY_HOLD_CYC = tesc_pkg::FACTORY_HOLD_CYC,
	parameter int SF_HALF_CYC = tesc_pkg::SF_HALF_CYC,
	parameter int BF_HALF_CYC = tesc_pkg::BF_HALF_CYC,
	parameter int DARK_HALF_CYC = tesc_pkg::DARK_HALF_CYC
) (
	input wire logic clk_i,
	input wire logic reset_n_i,
	input wire logic [3:0] avs_address_i,
	input wire logic avs_read_i,
	input wire logic avs_write_i,
	input wire logic [31:0] avs_writedata_i,
	input wire logic [3:0] avs_byteenable_i,
	output logic [31:0] avs_readdata_o,
	output logic avs_waitrequest_o,
	input wire logic multifunction_i,
	input wire logic sync_pair_i,
	input wire logic encoder_a_i,
	input wire logic encoder_b_i,
	input wire logic encoder_index_positive_i,
	input wire logic key_i,
	input wire tesc_pkg::tesc_cond_type cond_i,
	output tesc_pkg::tesc_lamps_type lamps_o,
	output logic trigger_o,
	output logic dark_start_o,
	output logic factory_reset_o,
	output logic irq_o
);
	initial begin
		if (POS_WIDTH < 2 || POS_WIDTH > 32 || FACTORY_HOLD_CYC < 2 || SF_HALF_CYC < 1 ||
				BF_HALF_CYC < 1 || DARK_HALF_CYC < 1) begin
			$error("tesc_top: unsupported parameter values");
		end
	end

	// ****************************************
	// State
	// ****************************************
	typedef struct packed {
		logic [1:0][5:0] sync1;
		logic [5:0] pins;
		logic [5:0] pins_d;
		logic [31:0] ctrl;
		logic [tesc_pkg::EV_WIDTH-1:0] status;
		logic [tesc_pkg::EV_WIDTH-1:0] mask;
		logic [POS_WIDTH-1:0] pos;
		logic [15:0] enc_step;
		logic [31:0] trig_cnt;
		logic ack;
		logic [31:0] rdata;
		tesc_pkg::tesc_key_type key_st;
		logic [39:0] key_cnt;
		logic [31:0] sf_cnt;
		logic sf_ph;
		logic [31:0] bf_cnt;
		logic bf_ph;
		logic [31:0] dk_cnt;
		logic dk_ph;
		logic trig;
		logic dark_start;
		logic factory;
		tesc_pkg::tesc_lamps_type lamps;
	} tesc_state_type;

	tesc_state_type s_r;
	tesc_state_type s_nxt;

	function automatic logic [31:0] blink_next(input logic [31:0] cnt, input int half);
		blink_next = (cnt >= 32'(half - 1)) ? 32'h0000_0000 : cnt + 32'h0000_0001;
	endfunction : blink_next

	function automatic logic [31:0] apply_be(input logic [31:0] old, input logic [31:0] wd,
			input logic [3:0] be);
		for (int i = 0; i < 4; i++) begin
			apply_be[i*8 +: 8] = be[i] ? wd[i*8 +: 8] : old[i*8 +: 8];
		end
	endfunction : apply_be

	logic [5:0] pin_raw;
	assign pin_raw = {key_i, encoder_index_positive_i, encoder_b_i, encoder_a_i,
		sync_pair_i, multifunction_i};

	always_comb begin
		logic mf_edge;
		logic sy_edge;
		logic enc_step_ev;
		logic quad_ev;
		logic dir_up;
		logic idx_rise;
		logic key_now;
		logic [tesc_pkg::EV_WIDTH-1:0] ev;
		tesc_pkg::tesc_src_type src;
		logic edge_fall;
		logic [15:0] div;
		logic access;
		mf_edge = 1'b0;
		sy_edge = 1'b0;
		enc_step_ev = 1'b0;
		quad_ev = 1'b0;
		dir_up = 1'b0;
		idx_rise = 1'b0;
		key_now = 1'b0;
		ev = '0;
		src = tesc_pkg::tesc_src_type'(s_r.ctrl[tesc_pkg::CTRL_SRC_LSB +: 2]);
		edge_fall = s_r.ctrl[tesc_pkg::CTRL_TRIG_EDGE];
		div = s_r.ctrl[tesc_pkg::CTRL_ENC_DIV_LSB +: 16];
		access = avs_read_i || avs_write_i;
		s_nxt = s_r;

		// Three flops per pin before use
		s_nxt.sync1[0] = pin_raw;
		s_nxt.sync1[1] = s_r.sync1[0];
		s_nxt.pins = s_r.sync1[1];
		s_nxt.pins_d = s_r.pins;

		// ****************************************
		// Trigger sources
		// ****************************************
		mf_edge = edge_fall ? (s_r.pins_d[0] && !s_r.pins[0]) : (!s_r.pins_d[0] && s_r.pins[0]);
		sy_edge = edge_fall ? (s_r.pins_d[1] && !s_r.pins[1]) : (!s_r.pins_d[1] && s_r.pins[1]);

		// Quadrature: one step per A or B transition, direction from phase
		quad_ev = (s_r.pins[2] ^ s_r.pins_d[2]) ^ (s_r.pins[3] ^ s_r.pins_d[3]);
		dir_up = s_r.pins[2] ^ s_r.pins_d[3];
		idx_rise = !s_r.pins_d[4] && s_r.pins[4];
		// Both channels moving at once is a lost step, ignored; 1 MHz gives 100 cycles per edge
		if (idx_rise) begin
			s_nxt.pos = '0;
			ev[tesc_pkg::EV_INDEX] = 1'b1;
		end else if (quad_ev) begin
			s_nxt.pos = dir_up ? s_r.pos + 1'b1 : s_r.pos - 1'b1;
		end
		// Encoder trigger every div+1 steps
		if (quad_ev) begin
			if (s_r.enc_step >= div) begin
				s_nxt.enc_step = '0;
				enc_step_ev = 1'b1;
			end else begin
				s_nxt.enc_step = s_r.enc_step + 16'h0001;
			end
		end

		s_nxt.trig = 1'b0;
		unique case (src)
			tesc_pkg::SRC_MULTIFUNCTION: s_nxt.trig = mf_edge && s_r.ctrl[tesc_pkg::CTRL_MF_TRIG];
			tesc_pkg::SRC_SYNC_PAIR: s_nxt.trig = sy_edge && s_r.ctrl[tesc_pkg::CTRL_SYNC_TRIG];
			tesc_pkg::SRC_ENCODER: s_nxt.trig = enc_step_ev && s_r.ctrl[tesc_pkg::CTRL_ENC_TRIG];
			tesc_pkg::SRC_NONE: s_nxt.trig = 1'b0;
		endcase
		if (s_nxt.trig) begin
			s_nxt.trig_cnt = s_r.trig_cnt + 32'h0000_0001;
			ev[tesc_pkg::EV_TRIG] = 1'b1;
		end

		// ****************************************
		// Front key
		// ****************************************
		key_now = s_r.pins[5];
		s_nxt.dark_start = 1'b0;
		s_nxt.factory = 1'b0;
		unique case (s_r.key_st)
			tesc_pkg::KEY_IDLE: begin
				s_nxt.key_cnt = '0;
				if (key_now) begin
					if (s_r.ctrl[tesc_pkg::CTRL_KEY_OFF] || s_r.ctrl[tesc_pkg::CTRL_KEY_LOCK]) begin
						ev[tesc_pkg::EV_KEY_BLOCKED] = 1'b1;
						s_nxt.key_st = tesc_pkg::KEY_DONE;
					end else begin
						s_nxt.key_st = tesc_pkg::KEY_HELD;
					end
				end
			end
			tesc_pkg::KEY_HELD: begin
				s_nxt.key_cnt = s_r.key_cnt + 40'h00_0000_0001;
				if (!key_now) begin
					// Short press on release starts dark correction
					s_nxt.dark_start = 1'b1;
					ev[tesc_pkg::EV_DARK] = 1'b1;
					s_nxt.key_st = tesc_pkg::KEY_IDLE;
				end else if (s_r.key_cnt >= 40'(FACTORY_HOLD_CYC)) begin
					// Factory reset only; address and name are kept elsewhere
					s_nxt.factory = 1'b1;
					ev[tesc_pkg::EV_FACTORY] = 1'b1;
					s_nxt.key_st = tesc_pkg::KEY_DONE;
				end
			end
			tesc_pkg::KEY_DONE: begin
				if (!key_now) begin
					s_nxt.key_st = tesc_pkg::KEY_IDLE;
				end
			end
			default: s_nxt.key_st = tesc_pkg::KEY_IDLE;
		endcase

		// ****************************************
		// Lamps
		// ****************************************
		s_nxt.sf_cnt = blink_next(s_r.sf_cnt, SF_HALF_CYC);
		if (s_r.sf_cnt == 32'h0000_0000) begin
			s_nxt.sf_ph = !s_r.sf_ph;
		end
		s_nxt.bf_cnt = blink_next(s_r.bf_cnt, BF_HALF_CYC);
		if (s_r.bf_cnt == 32'h0000_0000) begin
			s_nxt.bf_ph = !s_r.bf_ph;
		end
		s_nxt.dk_cnt = blink_next(s_r.dk_cnt, DARK_HALF_CYC);
		if (s_r.dk_cnt == 32'h0000_0000) begin
			s_nxt.dk_ph = !s_r.dk_ph;
		end

		if (cond_i.dark_active) begin
			s_nxt.lamps.intensity = s_r.dk_ph ? tesc_pkg::LAMP_RED : tesc_pkg::LAMP_OFF;
			s_nxt.lamps.range = s_r.dk_ph ? tesc_pkg::LAMP_RED : tesc_pkg::LAMP_OFF;
		end else begin
			if (cond_i.saturated) begin
				s_nxt.lamps.intensity = tesc_pkg::LAMP_RED;
			end else if (cond_i.too_weak) begin
				s_nxt.lamps.intensity = tesc_pkg::LAMP_YELLOW;
			end else begin
				s_nxt.lamps.intensity = tesc_pkg::LAMP_GREEN;
			end
			if (cond_i.no_target) begin
				s_nxt.lamps.range = tesc_pkg::LAMP_RED;
			end else if (cond_i.mid_span) begin
				s_nxt.lamps.range = tesc_pkg::LAMP_YELLOW;
			end else begin
				s_nxt.lamps.range = tesc_pkg::LAMP_GREEN;
			end
		end
		// Steady faults outrank the signal-service flash
		if (cond_i.watchdog || cond_i.diagnosis || cond_i.system_error) begin
			s_nxt.lamps.system_fault_lamp = 1'b1;
		end else begin
			s_nxt.lamps.system_fault_lamp = cond_i.dcp_signal && s_r.sf_ph;
		end
		if (cond_i.no_config || cond_i.link_down) begin
			s_nxt.lamps.bus_fault_lamp = 1'b1;
		end else begin
			s_nxt.lamps.bus_fault_lamp = cond_i.no_exchange && s_r.bf_ph;
		end

		// ****************************************
		// Bus slave: one wait cycle, then answer
		// ****************************************
		s_nxt.ack = access && !s_r.ack;
		s_nxt.status = s_r.status;
		if (access && !s_r.ack) begin
			unique case (avs_address_i)
				tesc_pkg::ADDR_CTRL: s_nxt.rdata = s_r.ctrl;
				tesc_pkg::ADDR_STATE: s_nxt.rdata = {22'h00_0000, s_r.pins, s_r.key_st,
					s_r.lamps.system_fault_lamp, s_r.lamps.bus_fault_lamp};
				tesc_pkg::ADDR_STATUS: s_nxt.rdata = {27'h000_0000, s_r.status};
				tesc_pkg::ADDR_MASK: s_nxt.rdata = {27'h000_0000, s_r.mask};
				tesc_pkg::ADDR_POS: s_nxt.rdata = 32'(s_r.pos);
				tesc_pkg::ADDR_TRIGCNT: s_nxt.rdata = s_r.trig_cnt;
				default: s_nxt.rdata = 32'h0000_0000;
			endcase
		end
		if (s_r.ack && avs_write_i) begin
			unique case (avs_address_i)
				tesc_pkg::ADDR_CTRL: s_nxt.ctrl = apply_be(s_r.ctrl, avs_writedata_i, avs_byteenable_i);
				tesc_pkg::ADDR_MASK: if (avs_byteenable_i[0]) begin
					s_nxt.mask = avs_writedata_i[tesc_pkg::EV_WIDTH-1:0];
				end
				default: ;
			endcase
		end
		if (s_r.ack && avs_read_i && avs_address_i == tesc_pkg::ADDR_STATUS) begin
			s_nxt.status = '0;
		end
		// New events win over the read clear
		s_nxt.status = s_nxt.status | ev;

		if (!reset_n_i) begin
			s_nxt = '0;
			s_nxt.ctrl = tesc_pkg::CTRL_RESET;
			s_nxt.key_st = tesc_pkg::KEY_IDLE;
		end
	end

	always_ff @(posedge clk_i) begin
		s_r <= s_nxt;
	end

	assign avs_waitrequest_o = (avs_read_i || avs_write_i) && !s_r.ack;
	assign avs_readdata_o = s_r.rdata;
	assign lamps_o = s_r.lamps;
	assign trigger_o = s_r.trig;
	assign dark_start_o = s_r.dark_start;
	assign factory_reset_o = s_r.factory;
	assign irq_o = |(s_r.status & s_r.mask);
endmodule : tesc_top

//--- include/tesc_pkg.sv
package tesc_pkg;
	// ****************************************
	// Register map (word addresses on the bus)
	// ****************************************
	localparam logic [3:0] ADDR_CTRL = 4'h0;
	localparam logic [3:0] ADDR_STATE = 4'h1;
	localparam logic [3:0] ADDR_STATUS = 4'h2;
	localparam logic [3:0] ADDR_MASK = 4'h3;
	localparam logic [3:0] ADDR_POS = 4'h4;
	localparam logic [3:0] ADDR_TRIGCNT = 4'h5;

	// ****************************************
	// Control register fields
	// ****************************************
	localparam int CTRL_SRC_LSB = 0;
	localparam int CTRL_MF_TRIG = 2;
	localparam int CTRL_SYNC_TRIG = 3;
	localparam int CTRL_ENC_TRIG = 4;
	localparam int CTRL_KEY_OFF = 5;
	localparam int CTRL_KEY_LOCK = 6;
	localparam int CTRL_TRIG_EDGE = 7;
	localparam int CTRL_ENC_DIV_LSB = 8;
	localparam logic [31:0] CTRL_RESET = 32'h0000_0000;

	// ****************************************
	// Status / event bits
	// ****************************************
	localparam int EV_TRIG = 0;
	localparam int EV_DARK = 1;
	localparam int EV_FACTORY = 2;
	localparam int EV_INDEX = 3;
	localparam int EV_KEY_BLOCKED = 4;
	localparam int EV_WIDTH = 5;

	// ****************************************
	// Timing
	// ****************************************
	localparam int CLK_HZ = 100_000_000;
	localparam int SF_BLINK_HZ = 1;
	localparam int BF_BLINK_HZ = 2;
	localparam int DARK_BLINK_HZ = 4;
	localparam int FACTORY_HOLD_S = 10;
	localparam int SF_HALF_CYC = CLK_HZ / (2 * SF_BLINK_HZ);
	localparam int BF_HALF_CYC = CLK_HZ / (2 * BF_BLINK_HZ);
	localparam int DARK_HALF_CYC = CLK_HZ / (2 * DARK_BLINK_HZ);
	localparam longint FACTORY_HOLD_CYC = longint'(CLK_HZ) * FACTORY_HOLD_S;
	localparam int ENC_MAX_HZ = 1_000_000;
	localparam int ENC_MIN_CYC = CLK_HZ / ENC_MAX_HZ;

	typedef enum logic [1:0] {
		SRC_MULTIFUNCTION,
		SRC_SYNC_PAIR,
		SRC_ENCODER,
		SRC_NONE
	} tesc_src_type;

	typedef enum logic [1:0] {
		LAMP_OFF,
		LAMP_RED,
		LAMP_YELLOW,
		LAMP_GREEN
	} tesc_color_type;

	typedef enum logic [1:0] {
		KEY_IDLE,
		KEY_HELD,
		KEY_DONE
	} tesc_key_type;

	typedef struct packed {
		logic dark_active;
		logic saturated;
		logic too_weak;
		logic no_target;
		logic mid_span;
		logic dcp_signal;
		logic watchdog;
		logic diagnosis;
		logic system_error;
		logic no_exchange;
		logic no_config;
		logic link_down;
	} tesc_cond_type;

	typedef struct packed {
		tesc_color_type intensity;
		tesc_color_type range;
		logic system_fault_lamp;
		logic bus_fault_lamp;
	} tesc_lamps_type;
endpackage : tesc_pkg

//--- test/tesc_partner.sv
`timescale 1ns/1ps
// ********
// Far side: encoder and sync pair source
// ********
module tesc_partner (
	input wire logic clk_i,
	input wire logic step_up_i,
	input wire logic step_dn_i,
	input wire logic sync_level_i,
	output logic enc_a_o,
	output logic enc_b_o,
	output logic sync_pair_o
);
	logic [1:0] phase_r = 2'h0;
	always_ff @(posedge clk_i) begin
		if (step_up_i) begin
			phase_r <= phase_r + 2'h1;
		end else if (step_dn_i) begin
			phase_r <= phase_r - 2'h1;
		end
	end
	// Gray order: one channel moves per step
	assign enc_a_o = (phase_r == 2'h1) || (phase_r == 2'h2);
	assign enc_b_o = phase_r[1];
	// Receiver leaves one level of the symmetric pair
	assign sync_pair_o = sync_level_i;
endmodule : tesc_partner

//--- test/tesc_sva.sv
`timescale 1ns/1ps
module tesc_sva (
	input wire logic clk_i,
	input wire logic reset_n_i,
	input wire tesc_pkg::tesc_cond_type cond_i,
	input wire tesc_pkg::tesc_lamps_type lamps_o,
	input wire logic trigger_o,
	input wire logic dark_start_o,
	input wire logic factory_reset_o
);
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!reset_n_i);
	wire sf_hard = cond_i.watchdog | cond_i.diagnosis | cond_i.system_error;
	wire bf_hard = cond_i.no_config | cond_i.link_down;
	property p_intensity;
		reset_n_i && !cond_i.dark_active ##1 $stable(cond_i) |-> lamps_o.intensity == (cond_i.saturated ?
			tesc_pkg::LAMP_RED : cond_i.too_weak ? tesc_pkg::LAMP_YELLOW : tesc_pkg::LAMP_GREEN);
	endproperty
	a_intensity: assert property (p_intensity) else $error("intensity lamp wrong");
	property p_range;
		reset_n_i && !cond_i.dark_active ##1 $stable(cond_i) |-> lamps_o.range == (cond_i.no_target ?
			tesc_pkg::LAMP_RED : cond_i.mid_span ? tesc_pkg::LAMP_YELLOW : tesc_pkg::LAMP_GREEN);
	endproperty
	a_range: assert property (p_range) else $error("range lamp wrong");
	property p_dark;
		cond_i.dark_active ##1 cond_i.dark_active |-> lamps_o.range == lamps_o.intensity &&
			lamps_o.range inside {tesc_pkg::LAMP_RED, tesc_pkg::LAMP_OFF};
	endproperty
	a_dark: assert property (p_dark) else $error("dark flash wrong");
	property p_sf_steady;
		sf_hard |=> lamps_o.system_fault_lamp;
	endproperty
	a_sf_steady: assert property (p_sf_steady) else $error("system lamp not steady");
	property p_sf_off;
		!(sf_hard || cond_i.dcp_signal) |=> !lamps_o.system_fault_lamp;
	endproperty
	a_sf_off: assert property (p_sf_off) else $error("system lamp not off");
	property p_bf_steady;
		bf_hard |=> lamps_o.bus_fault_lamp;
	endproperty
	a_bf_steady: assert property (p_bf_steady) else $error("bus lamp not steady");
	property p_bf_off;
		!(bf_hard || cond_i.no_exchange) |=> !lamps_o.bus_fault_lamp;
	endproperty
	a_bf_off: assert property (p_bf_off) else $error("bus lamp not off");
	property p_trig_pulse;
		trigger_o |=> !trigger_o;
	endproperty
	a_trig_pulse: assert property (p_trig_pulse) else $error("trigger too long");
	property p_fact_pulse;
		factory_reset_o |-> !dark_start_o ##1 !factory_reset_o;
	endproperty
	a_fact_pulse: assert property (p_fact_pulse) else $error("factory pulse wrong");
endmodule : tesc_sva

//--- test/testbench.sv
`timescale 1ns/1ps
module testbench;
	logic clk_i = 1'b0;
	logic reset_n_i = 1'b0;
	logic [3:0] adr = 4'h0;
	logic rd = 1'b0;
	logic wr = 1'b0;
	logic [31:0] wdat = 32'h0;
	logic mf = 1'b0;
	logic syn = 1'b0;
	logic idx = 1'b0;
	logic key = 1'b0;
	logic up = 1'b0;
	logic dn = 1'b0;
	tesc_pkg::tesc_cond_type cond = '0;
	tesc_pkg::tesc_lamps_type lamps;
	logic [31:0] rdat;
	logic wt, enc_a, enc_b, syn_p, trig, dark, fact, irq;
	int fail_count = 0;
	int n_compared = 0;
	int n_trig = 0;
	int n_dark = 0;
	int n_fact = 0;
	int s, e, t0, k;
	logic [11:0] lamp_tab [10] = '{12'h400, 12'h200, 12'h000, 12'h100, 12'h080, 12'h020,
		12'h010, 12'h008, 12'h002, 12'h001};
	initial forever #5 clk_i = !clk_i;
	tesc_partner i_partner (.clk_i(clk_i), .step_up_i(up), .step_dn_i(dn), .sync_level_i(syn),
		.enc_a_o(enc_a), .enc_b_o(enc_b), .sync_pair_o(syn_p));
	tesc_top #(.FACTORY_HOLD_CYC(200), .SF_HALF_CYC(10), .BF_HALF_CYC(5), .DARK_HALF_CYC(4))
	i_dut (.clk_i(clk_i), .reset_n_i(reset_n_i), .avs_address_i(adr), .avs_read_i(rd),
		.avs_write_i(wr), .avs_writedata_i(wdat), .avs_byteenable_i(4'hF),
		.avs_readdata_o(rdat), .avs_waitrequest_o(wt), .multifunction_i(mf),
		.sync_pair_i(syn_p), .encoder_a_i(enc_a), .encoder_b_i(enc_b),
		.encoder_index_positive_i(idx), .key_i(key), .cond_i(cond), .lamps_o(lamps),
		.trigger_o(trig), .dark_start_o(dark), .factory_reset_o(fact), .irq_o(irq));
	// One-cycle pulses are seen exactly once at mid-cycle
	always @(negedge clk_i) begin
		n_trig += (trig === 1'b1);
		n_dark += (dark === 1'b1);
		n_fact += (fact === 1'b1);
	end
	// ********
	// Shared tasks
	// ********
	task automatic stop_test;
		if (fail_count == 0 && n_compared > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask : stop_test
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp) begin
			fail_count++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : check
	task automatic cyc(input int n);
		repeat (n) @(posedge clk_i);
	endtask : cyc
	// Read compares against d; answer is taken at the first falling edge with waitrequest low
	task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
		int i;
		i = 0;
		@(posedge clk_i);
		adr <= a;
		wr <= w;
		rd <= !w;
		wdat <= d;
		@(negedge clk_i);
		while (wt !== 1'b0 && i < 20) begin
			@(negedge clk_i);
			i++;
		end
		if (i == 20) begin
			fail_count++;
			stop_test();
		end
		if (!w) check(rdat, d);
		@(posedge clk_i);
		rd <= 1'b0;
		wr <= 1'b0;
	endtask : bus
	task automatic step(input logic u, input int n);
		repeat (n) begin
			@(posedge clk_i);
			up <= u;
			dn <= !u;
			@(posedge clk_i);
			up <= 1'b0;
			dn <= 1'b0;
			cyc(30);
		end
	endtask : step
	task automatic fire(input int src);
		if (src == 2) begin
			step(1'b1, 1);
		end else begin
			@(posedge clk_i);
			{mf, syn} <= (src == 0) ? 2'h2 : 2'h1;
			cyc(30);
			{mf, syn} <= 2'h0;
			cyc(30);
		end
	endtask : fire
	task automatic press(input int n);
		@(posedge clk_i);
		key <= 1'b1;
		cyc(n);
		key <= 1'b0;
		cyc(20);
	endtask : press
	initial begin
		#900_000;
		fail_count++;
		stop_test();
	end
	// ********
	// Main sequence
	// ********
	initial begin
		cyc(8);
		reset_n_i <= 1'b1;
		foreach (lamp_tab[k]) bus(1'b0, (k < 5) ? 4'(k) + 4'h1 : 4'hF, 32'h0);
		bus(1'b1, 4'hF, 32'hFFFF_FFFF);
		bus(1'b0, 4'hF, 32'h0);
		bus(1'b1, tesc_pkg::ADDR_CTRL, 32'h0012_3463);
		bus(1'b0, tesc_pkg::ADDR_CTRL, 32'h0012_3463);
		for (s = 0; s < 3; s++) begin
			for (e = 0; e < 2; e++) begin
				bus(1'b1, tesc_pkg::ADDR_CTRL, 32'(s) | (32'(e) << (2 + s)));
				t0 = n_trig;
				fire(s);
				check(32'(n_trig - t0), 32'(e));
			end
		end
		bus(1'b1, tesc_pkg::ADDR_CTRL, 32'h0000_0212);
		t0 = n_trig;
		step(1'b1, 6);
		check(32'(n_trig - t0), 32'h2);
		bus(1'b1, tesc_pkg::ADDR_CTRL, 32'h0000_0084);
		t0 = n_trig;
		fire(0);
		check(32'(n_trig - t0), 32'h1);
		bus(1'b0, tesc_pkg::ADDR_TRIGCNT, 32'h6);
		bus(1'b0, tesc_pkg::ADDR_STATUS, 32'h1);
		bus(1'b0, tesc_pkg::ADDR_STATUS, 32'h0);
		bus(1'b1, tesc_pkg::ADDR_CTRL, 32'h0000_0003);
		idx <= 1'b1;
		cyc(10);
		idx <= 1'b0;
		step(1'b1, 5);
		step(1'b0, 2);
		bus(1'b0, tesc_pkg::ADDR_POS, 32'h3);
		bus(1'b0, tesc_pkg::ADDR_STATUS, 32'h8);
		foreach (lamp_tab[k]) begin
			cond <= tesc_pkg::tesc_cond_type'(lamp_tab[k]);
			cyc(5);
		end
		for (s = 0; s < 3; s++) begin
			cond <= tesc_pkg::tesc_cond_type'((s == 0) ? 12'h040 : (s == 1) ? 12'h004 : 12'h800);
			cyc(30);
			@(negedge clk_i);
			e = 0;
			t0 = (s == 0) ? lamps.system_fault_lamp : (s == 1) ? lamps.bus_fault_lamp
				: (lamps.intensity == tesc_pkg::LAMP_RED);
			repeat (100) begin
				@(negedge clk_i);
				k = (s == 0) ? lamps.system_fault_lamp : (s == 1) ? lamps.bus_fault_lamp
					: (lamps.intensity == tesc_pkg::LAMP_RED);
				e += (k != t0);
				t0 = k;
			end
			check(32'(e), (s == 0) ? 32'd10 : (s == 1) ? 32'd20 : 32'd25);
		end
		cond <= '0;
		bus(1'b1, tesc_pkg::ADDR_CTRL, 32'h0);
		t0 = n_dark;
		press(20);
		check(32'(n_dark - t0), 32'h1);
		check({31'h0, irq}, 32'h0);
		bus(1'b1, tesc_pkg::ADDR_MASK, 32'h2);
		@(negedge clk_i);
		check({31'h0, irq}, 32'h1);
		bus(1'b0, tesc_pkg::ADDR_STATUS, 32'h2);
		cyc(2);
		check({31'h0, irq}, 32'h0);
		press(250);
		check(32'(n_fact), 32'h1);
		check(32'(n_dark - t0), 32'h1);
		bus(1'b0, tesc_pkg::ADDR_STATUS, 32'h4);
		for (s = 5; s < 7; s++) begin
			bus(1'b1, tesc_pkg::ADDR_CTRL, 32'h1 << s);
			press(20);
			check(32'(n_dark - t0), 32'h1);
			bus(1'b0, tesc_pkg::ADDR_STATUS, 32'h10);
		end
		stop_test();
	end
endmodule : testbench
bind tesc_top tesc_sva i_sva (.clk_i(clk_i), .reset_n_i(reset_n_i), .cond_i(cond_i),
	.lamps_o(lamps_o), .trigger_o(trigger_o), .dark_start_o(dark_start_o),
	.factory_reset_o(factory_reset_o));
